/* rtl/usttx_pkg.sv */
package usttx_pkg;
   localparam int DATA_W = 9;
   localparam int FIFO_DEPTH = 16;
   localparam logic [2:0] CHAR_SIZE_5 = 3'h0;
   localparam logic [2:0] CHAR_SIZE_6 = 3'h1;
   localparam logic [2:0] CHAR_SIZE_7 = 3'h2;
   localparam logic [2:0] CHAR_SIZE_8 = 3'h3;
   localparam logic [2:0] CHAR_SIZE_9 = 3'h7;
   localparam logic [4:0] DIV_NORMAL = 5'h10;
   localparam logic [4:0] DIV_DOUBLE = 5'h08;
   localparam logic [4:0] DIV_SYNC = 5'h02;
   localparam logic [3:0] BITS_BASE = 4'h5;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic START_LEVEL = 1'b0;
   typedef enum logic [2:0] {
      USTTX_IDLE = 3'b000,
      USTTX_START = 3'b001,
      USTTX_DATA = 3'b010,
      USTTX_PARITY = 3'b011,
      USTTX_STOP1 = 3'b100,
      USTTX_STOP2 = 3'b101
   } usttx_state_t;
endpackage

/* rtl/usttx_fifo.sv */
module usttx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // usttx_fifo

/* rtl/usttx_core.sv */
// Function
// RULE1 - Transmit enable takes the serial output pin from the port function.
// RULE2 - Synchronous mode with transmitter enabled uses the sync clock to time bits.
// RULE3 - Writing the data buffer loads the transmit buffer and starts a transfer.
// RULE4 - Buffer moves to shift register when idle or right after last stop bit.
// RULE5 - Shift register sends one whole frame at the selected bit rate.
// RULE6 - Characters under eight bits send only the configured low bits.
// RULE7 - Size code 7 sends the ninth bit, written before the low byte.
// RULE8 - Buffer-empty flag set while empty, cleared by write until moved.
// RULE9 - Buffer-empty interrupt requested while flag, enable and global enable are set.
// RULE10 - Software writes zero to the buffer-empty flag position.
// RULE11 - Buffer-empty handler writes data or clears its interrupt enable.
// RULE12 - Transmit-complete set when frame is out and buffer holds nothing.
// RULE13 - Transmit-complete cleared on interrupt service or by writing one.
// RULE14 - Transmit-complete interrupt requested when flag, enable and global enable set.
// RULE15 - Parity enabled inserts parity between last data bit and first stop bit.
// RULE16 - Disable waits until shift register and buffer have sent everything.
// RULE17 - Once effectively disabled, the serial pin returns to port function.
// RULE18 - Frame: low start, data LSB first, parity, stop; idle line high.
// RULE19 - Bit clock divides baud tick by 2, 8 or 16 per mode; sync mode here times bits from sync clock pin edges instead of baud tick / 2.
// RULE20 - Sync data changes on rising edge for polarity zero, falling for one.
// RULE21 - Parity type bit selects odd or even parity.
// RULE22 - Stop-bit select chooses one or two high stop bits.
// RULE23 - Even parity makes ones count even; odd parity makes it odd.
module usttx_core #(
   parameter int FIFO_DEPTH = usttx_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tx_enable,
   input wire logic sync_mode,
   input wire logic double_speed,
   input wire logic clock_polarity,
   input wire logic [2:0] char_size,
   input wire logic parity_enable_bit,
   input wire logic parity_odd_select,
   input wire logic stop_bit_select,
   input wire logic tx_ninth_bit,
   input wire logic baud_tick,
   input wire logic sync_clock_pin_in,
   input wire logic [7:0] data_buffer_wdata,
   input wire logic data_buffer_write,
   output logic data_buffer_ready,
   input wire logic tx_complete_write_one,
   input wire logic tx_complete_irq_ack,
   input wire logic buffer_empty_irq_en,
   input wire logic tx_complete_irq_en,
   input wire logic global_irq_en,
   output logic tx_buffer_empty,
   output logic tx_complete,
   output logic buffer_empty_irq,
   output logic tx_complete_irq,
   output logic serial_out,
   output logic serial_out_en,
   output logic tx_active
);
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic fifo_in_ready;
   logic [usttx_pkg::DATA_W-1:0] fifo_out_data;
   logic [usttx_pkg::DATA_W-1:0] fifo_in_data;
   logic sck_meta_reg;
   logic sck_sync_reg;
   logic sck_prev_reg;
   logic [4:0] div_cnt_reg;
   logic bit_tick;
   logic [4:0] div_limit;
   logic sync_edge;
   usttx_pkg::usttx_state_t state_reg;
   logic [usttx_pkg::DATA_W-1:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [3:0] nbits;
   logic parity_reg;
   logic en_eff_reg;
   logic load;
   logic frame_done;
   logic empty_now;
   logic start_armed_reg;
   logic last_data;

   // Character width: low bits only for short sizes, ninth bit for size code 7
   always_comb begin
      fifo_in_data = '0;
      case (char_size)
         usttx_pkg::CHAR_SIZE_5: fifo_in_data = {4'h0, data_buffer_wdata[4:0]}; // see RULE6
         usttx_pkg::CHAR_SIZE_6: fifo_in_data = {3'h0, data_buffer_wdata[5:0]}; // see RULE6
         usttx_pkg::CHAR_SIZE_7: fifo_in_data = {2'h0, data_buffer_wdata[6:0]}; // see RULE6
         usttx_pkg::CHAR_SIZE_9: fifo_in_data = {tx_ninth_bit, data_buffer_wdata}; // see RULE7
         default: fifo_in_data = {1'b0, data_buffer_wdata};
      endcase
   end

   always_comb begin
      nbits = 4'h8;
      case (char_size)
         usttx_pkg::CHAR_SIZE_5: nbits = usttx_pkg::BITS_BASE;
         usttx_pkg::CHAR_SIZE_6: nbits = usttx_pkg::BITS_BASE + 4'h1;
         usttx_pkg::CHAR_SIZE_7: nbits = usttx_pkg::BITS_BASE + 4'h2;
         usttx_pkg::CHAR_SIZE_9: nbits = 4'h9;
         default: nbits = 4'h8;
      endcase
   end

   // Write into the transmit buffer queue starts a transfer
   usttx_fifo #(
      .WIDTH(usttx_pkg::DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(data_buffer_write && en_eff_reg), // see RULE3
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Sync clock pin passes two flops before the edge detector
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sck_meta_reg <= 1'b0;
         sck_sync_reg <= 1'b0;
         sck_prev_reg <= 1'b0;
      end else begin
         sck_meta_reg <= sync_clock_pin_in;
         sck_sync_reg <= sck_meta_reg;
         sck_prev_reg <= sck_sync_reg;
      end
   end

   // Polarity zero shifts on rising edge, one on falling edge
   assign sync_edge = clock_polarity ? (sck_prev_reg && !sck_sync_reg)
                                     : (!sck_prev_reg && sck_sync_reg); // see RULE20

   always_comb begin
      if (sync_mode) begin
         div_limit = usttx_pkg::DIV_SYNC;
      end else if (double_speed) begin
         div_limit = usttx_pkg::DIV_DOUBLE;
      end else begin
         div_limit = usttx_pkg::DIV_NORMAL;
      end
   end

   // Async modes divide the baud tick; sync mode times bits from the pin edges
   always_ff @(posedge clk) begin
      if (!nrst) begin
         div_cnt_reg <= '0;
      end else if (baud_tick) begin
         div_cnt_reg <= (div_cnt_reg >= div_limit - 5'h1) ? 5'h0 // see RULE19
                                                           : div_cnt_reg + 5'h1;
      end
   end

   assign bit_tick = sync_mode ? sync_edge // see RULE2
                               : (baud_tick && (div_cnt_reg >= div_limit - 5'h1)); // see RULE5

   // Load when idle or in the cycle the last stop bit ends
   assign frame_done = bit_tick && ((state_reg == usttx_pkg::USTTX_STOP2) ||
                       (state_reg == usttx_pkg::USTTX_STOP1 && !stop_bit_select));
   assign load = fifo_out_valid && // see RULE4
                 ((state_reg == usttx_pkg::USTTX_IDLE) || frame_done);
   assign fifo_out_ready = load;
   assign last_data = (bit_cnt_reg == nbits - 4'h1);

   // A load from idle is off the bit grid, so the start bit waits for the next tick
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= usttx_pkg::USTTX_IDLE;
      end else if (load) begin
         state_reg <= usttx_pkg::USTTX_START;
      end else if (bit_tick) begin
         case (state_reg)
            usttx_pkg::USTTX_START: begin
               if (start_armed_reg) begin
                  state_reg <= usttx_pkg::USTTX_DATA;
               end
            end
            usttx_pkg::USTTX_DATA: begin
               if (last_data) begin
                  state_reg <= parity_enable_bit ? usttx_pkg::USTTX_PARITY // see RULE15
                                                 : usttx_pkg::USTTX_STOP1;
               end
            end
            usttx_pkg::USTTX_PARITY: state_reg <= usttx_pkg::USTTX_STOP1;
            usttx_pkg::USTTX_STOP1: begin
               state_reg <= stop_bit_select ? usttx_pkg::USTTX_STOP2 // see RULE22
                                            : usttx_pkg::USTTX_IDLE;
            end
            usttx_pkg::USTTX_STOP2: state_reg <= usttx_pkg::USTTX_IDLE;
            default: state_reg <= usttx_pkg::USTTX_IDLE;
         endcase
      end
   end

   // Back-to-back loads sit on a tick already, so their start bit goes out at once
   always_ff @(posedge clk) begin
      if (!nrst) begin
         start_armed_reg <= 1'b0;
      end else if (load) begin
         start_armed_reg <= frame_done;
      end else if (bit_tick && state_reg == usttx_pkg::USTTX_START) begin
         start_armed_reg <= 1'b1; // see RULE18
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         shift_reg <= '0;
      end else if (load) begin
         shift_reg <= fifo_out_data;
      end else if (bit_tick && state_reg == usttx_pkg::USTTX_DATA) begin
         shift_reg <= {1'b0, shift_reg[usttx_pkg::DATA_W-1:1]}; // see RULE18
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         bit_cnt_reg <= '0;
      end else if (load) begin
         bit_cnt_reg <= '0;
      end else if (bit_tick && state_reg == usttx_pkg::USTTX_DATA) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1; // see RULE6
      end
   end

   // Parity over the stored data, already masked to the character size
   always_ff @(posedge clk) begin
      if (!nrst) begin
         parity_reg <= 1'b0;
      end else if (load) begin
         parity_reg <= ^fifo_out_data ^ parity_odd_select; // see RULE21 see RULE23
      end
   end

   // Frame shape on the line, idle high
   always_ff @(posedge clk) begin
      if (!nrst) begin
         serial_out <= 1'b1;
      end else begin
         case (state_reg)
            usttx_pkg::USTTX_START: serial_out <= start_armed_reg ? usttx_pkg::START_LEVEL
                                                                   : usttx_pkg::LINE_IDLE; // see RULE18
            usttx_pkg::USTTX_DATA: serial_out <= shift_reg[0]; // see RULE18
            usttx_pkg::USTTX_PARITY: serial_out <= parity_reg; // see RULE15
            default: serial_out <= usttx_pkg::LINE_IDLE; // see RULE22
         endcase
      end
   end

   assign empty_now = !fifo_out_valid;

   // Disable deferred until buffer and shifter are drained
   always_ff @(posedge clk) begin
      if (!nrst) begin
         en_eff_reg <= 1'b0;
      end else if (tx_enable) begin
         en_eff_reg <= 1'b1; // see RULE1
      end else if (empty_now && state_reg == usttx_pkg::USTTX_IDLE && !load &&
                   !data_buffer_write) begin
         en_eff_reg <= 1'b0; // see RULE16
      end
   end

   // Pin ownership follows the effective enable, not the request
   always_ff @(posedge clk) begin
      if (!nrst) begin
         serial_out_en <= 1'b0;
      end else begin
         serial_out_en <= en_eff_reg; // see RULE1 see RULE17
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_active <= 1'b0;
      end else begin
         tx_active <= (state_reg != usttx_pkg::USTTX_IDLE);
      end
   end

   // Flag lags one cycle behind the queue; a write clears it at once
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_buffer_empty <= 1'b1;
      end else begin
         tx_buffer_empty <= empty_now && !(data_buffer_write && en_eff_reg); // see RULE8
      end
   end

   // Ready is one cycle late; a write into a full queue is dropped
   always_ff @(posedge clk) begin
      if (!nrst) begin
         data_buffer_ready <= 1'b1;
      end else begin
         data_buffer_ready <= fifo_in_ready;
      end
   end

   // Set wins over clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_complete <= 1'b0;
      end else if (frame_done && !fifo_out_valid) begin
         tx_complete <= 1'b1; // see RULE12
      end else if (tx_complete_write_one || tx_complete_irq_ack) begin
         tx_complete <= 1'b0; // see RULE13
      end
   end

   // Level requests; the complete request follows the flag and drops on service
   always_ff @(posedge clk) begin
      if (!nrst) begin
         buffer_empty_irq <= 1'b0;
         tx_complete_irq <= 1'b0;
      end else begin
         buffer_empty_irq <= buffer_empty_irq_en && global_irq_en && empty_now &&
                             !(data_buffer_write && en_eff_reg); // see RULE9
         tx_complete_irq <= tx_complete_irq_en && global_irq_en &&
                            ((tx_complete && !tx_complete_write_one && !tx_complete_irq_ack) ||
                             (frame_done && !fifo_out_valid)); // see RULE14
      end
   end
endmodule // usttx_core

/* verif/usttx_core_assertions.sv */
module usttx_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tx_enable,
   input wire logic data_buffer_write,
   input wire logic tx_complete_write_one,
   input wire logic tx_complete_irq_ack,
   input wire logic buffer_empty_irq_en,
   input wire logic tx_complete_irq_en,
   input wire logic global_irq_en,
   input wire logic tx_buffer_empty,
   input wire logic tx_complete,
   input wire logic buffer_empty_irq,
   input wire logic tx_complete_irq,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic tx_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_idle; !tx_active |-> serial_out; endproperty
   a_idle: assert property (p_idle) else $error("line low while idle");
   property p_wr; data_buffer_write && serial_out_en |=> !tx_buffer_empty; endproperty
   a_wr: assert property (p_wr) else $error("empty flag after write");
   property p_beirq;
      (tx_buffer_empty && buffer_empty_irq_en && global_irq_en) [*2] |-> buffer_empty_irq;
   endproperty
   a_beirq: assert property (p_beirq) else $error("empty irq missing");
   property p_tcirq;
      (tx_complete && tx_complete_irq_en && global_irq_en) [*2] |-> tx_complete_irq;
   endproperty
   a_tcirq: assert property (p_tcirq) else $error("complete irq missing");
   property p_clr;
      (tx_complete_write_one || tx_complete_irq_ack) && !tx_active && !$past(tx_active) &&
         tx_buffer_empty |=> !tx_complete;
   endproperty
   a_clr: assert property (p_clr) else $error("complete flag not cleared");
   property p_set; $fell(tx_active) && tx_buffer_empty |-> ##[0:2] tx_complete; endproperty
   a_set: assert property (p_set) else $error("complete flag not set");
   property p_rel;
      $fell(serial_out_en) |-> !tx_active && tx_buffer_empty && !tx_enable;
   endproperty
   a_rel: assert property (p_rel) else $error("pin released early");
   property p_en; tx_enable [*2] |=> serial_out_en; endproperty
   a_en: assert property (p_en) else $error("pin not taken");
endmodule // usttx_chk
bind usttx_core usttx_chk i_chk (.*);

/* verif/usttx_rx_model.sv */
module usttx_rx_model (
   input wire logic clk,
   input wire logic line,
   input wire logic line_en,
   input var int bit_clks,
   input var int nbits,
   input wire logic par_en,
   input wire logic stop2
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] q [$];
   logic [8:0] d;
   logic p;
   logic s;
   // Samples mid-bit on the falling clock, away from the line's update edge
   initial begin
      forever begin
         @(negedge line iff line_en);
         repeat (bit_clks / 2) @(negedge clk);
         d = '0;
         for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(negedge clk);
            d[i] = line;
         end
         p = 1'b0;
         if (par_en) begin
            repeat (bit_clks) @(negedge clk);
            p = line;
         end
         repeat (bit_clks) @(negedge clk);
         s = line;
         if (stop2) begin
            repeat (bit_clks) @(negedge clk);
            s = s & line;
         end
         q.push_back({s, p, d});
      end
   end
endmodule // usttx_rx_model

/* verif/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, nrst = 1'b0, tx_enable = 1'b0, sync_mode = 1'b0, double_speed = 1'b0;
   logic clock_polarity = 1'b0, parity_enable_bit = 1'b0, parity_odd_select = 1'b0;
   logic stop_bit_select = 1'b0, tx_ninth_bit = 1'b0, baud_tick = 1'b0, sync_clock_pin_in = 1'b0;
   logic data_buffer_write = 1'b0, tx_complete_write_one = 1'b0, tx_complete_irq_ack = 1'b0;
   logic buffer_empty_irq_en = 1'b0, tx_complete_irq_en = 1'b0, global_irq_en = 1'b0;
   logic [2:0] char_size = 3'h3;
   logic [2:0] pdiv = 3'h0;
   logic [7:0] data_buffer_wdata = 8'h00;
   logic data_buffer_ready, tx_buffer_empty, tx_complete, buffer_empty_irq, tx_complete_irq;
   logic serial_out, serial_out_en, tx_active;
   logic [2:0] codes [5];
   int bit_clks = 32, nbits = 8, errors = 0, n_checks = 0, k;
   usttx_core i_dut (.*);
   // Released pin is pulled up, so the model never sees a stale level
   usttx_rx_model i_rx (
      .clk(clk),
      .line(serial_out_en ? serial_out : 1'b1),
      .line_en(serial_out_en),
      .bit_clks(bit_clks),
      .nbits(nbits),
      .par_en(parity_enable_bit),
      .stop2(stop_bit_select)
   );
   initial begin
      forever #2 clk = ~clk;
   end
   // Remote clock runs only while there is something to send
   always @(posedge clk) begin
      baud_tick <= ~baud_tick;
      if (sync_mode && (tx_active || !tx_buffer_empty)) begin
         pdiv <= pdiv + 3'h1;
         if (pdiv == 3'h7) sync_clock_pin_in <= ~sync_clock_pin_in;
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
      n_checks++;
      if (e !== g) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic put(input logic [8:0] v);
      data_buffer_wdata <= v[7:0];
      tx_ninth_bit <= v[8];
      data_buffer_write <= 1'b1;
      @(posedge clk);
      data_buffer_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic expect_rx(input logic [8:0] v);
      logic [8:0] m;
      logic [10:0] got;
      m = v & ((9'h001 << nbits) - 9'h001);
      for (int t = 0; t < 2000 && i_rx.q.size() == 0; t++) @(posedge clk);
      got = i_rx.q.size() > 0 ? i_rx.q.pop_front() : 11'hXXX;
      chk("frame", {1'b1, parity_enable_bit & (^m ^ parity_odd_select), m}, got);
   endtask
   initial begin
      #100000;
      errors++;
      end_of_test();
   end
   initial begin
      codes = '{usttx_pkg::CHAR_SIZE_5, usttx_pkg::CHAR_SIZE_6, usttx_pkg::CHAR_SIZE_7,
         usttx_pkg::CHAR_SIZE_8, usttx_pkg::CHAR_SIZE_9};
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      tx_enable <= 1'b1;
      buffer_empty_irq_en <= 1'b1;
      tx_complete_irq_en <= 1'b1;
      global_irq_en <= 1'b1;
      repeat (3) @(posedge clk);
      chk("pin owned", 11'h001, serial_out_en);
      chk("empty irq", 11'h001, buffer_empty_irq);
      for (int i = 0; i < 5; i++) begin
         char_size <= codes[i];
         parity_enable_bit <= i % 3 != 0;
         parity_odd_select <= i % 3 == 2;
         stop_bit_select <= i % 2 == 1;
         nbits = 5 + i;
         @(posedge clk);
         put(9'h1E6 ^ i[8:0]);
         expect_rx(9'h1E6 ^ i[8:0]);
         repeat (2 * bit_clks) @(posedge clk);
         chk("complete", 11'h001, tx_complete);
         chk("complete irq", 11'h001, tx_complete_irq);
         // Even passes clear the complete flag by writing one, odd passes by interrupt service
         tx_complete_write_one <= i % 2 == 0;
         tx_complete_irq_ack <= i % 2 == 1;
         @(posedge clk);
         tx_complete_write_one <= 1'b0;
         tx_complete_irq_ack <= 1'b0;
         repeat (2) @(posedge clk);
         chk("cleared", 11'h000, tx_complete);
      end
      for (int m = 0; m < 3; m++) begin
         repeat (bit_clks) @(posedge clk);
         bit_clks = 16;
         double_speed <= m == 0;
         sync_mode <= m > 0;
         clock_polarity <= m == 2;
         @(posedge clk);
         put(9'h0C3 ^ m[8:0]);
         expect_rx(9'h0C3 ^ m[8:0]);
      end
      repeat (bit_clks) @(posedge clk);
      sync_mode <= 1'b0;
      double_speed <= 1'b1;
      char_size <= usttx_pkg::CHAR_SIZE_8;
      parity_enable_bit <= 1'b0;
      nbits = 8;
      k = 0;
      @(posedge clk);
      while (data_buffer_ready && k < 40) begin
         put(k[8:0]);
         k++;
         @(posedge clk);
      end
      chk("accepted", 11'h011, k[10:0]);
      chk("empty flag", 11'h000, tx_buffer_empty);
      chk("empty irq off", 11'h000, buffer_empty_irq);
      tx_enable <= 1'b0;
      for (int j = 0; j < k; j++) begin
         chk("pin held", 11'h001, serial_out_en);
         expect_rx(j[8:0]);
      end
      repeat (2 * bit_clks) @(posedge clk);
      chk("pin released", 11'h000, serial_out_en);
      put(9'h055);
      repeat (400) @(posedge clk);
      chk("dropped", 11'h000, 11'(i_rx.q.size()));
      end_of_test();
   end
endmodule // testbench
